//--- logic/smlr_pkg.sv
// constants and types shared by the serial master and display refresh logic
package smlr_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] SMLR_OFF_DATA = 8'h00;
  localparam logic [7:0] SMLR_OFF_CTRL = 8'h04;
  localparam logic [7:0] SMLR_OFF_STAT = 8'h08;
  localparam logic [7:0] SMLR_OFF_ICLR = 8'h0C;
  localparam logic [7:0] SMLR_OFF_IEN  = 8'h10;
  localparam logic [7:0] SMLR_OFF_DISP = 8'h14;

  // ==========================================================================
  // control register fields
  localparam int         SMLR_CTRL_RATE_LO = 0;
  localparam int         SMLR_CTRL_RATE_HI = 1;
  localparam int         SMLR_CTRL_CLOCK_PHASE_SELECT    = 2;
  localparam int         SMLR_CTRL_CLOCK_POLARITY_SELECT    = 3;
  localparam int         SMLR_CTRL_REFRESH = 4;
  localparam int         SMLR_CTRL_W       = 5;
  localparam logic [4:0] SMLR_CTRL_RESET   = 5'h00;

  // ==========================================================================
  // event / status fields
  localparam int         SMLR_EV_XFER   = 0;
  localparam int         SMLR_EV_FRAME  = 1;
  localparam int         SMLR_EV_W      = 2;
  localparam int         SMLR_STAT_BUSY = 8;
  localparam int         SMLR_STAT_INV  = 9;
  localparam logic [1:0] SMLR_EV_RESET  = 2'h0;

  // ==========================================================================
  // display register fields
  localparam int         SMLR_DIGIT_W      = 4;
  localparam int         SMLR_DISP_UNITS   = 0;
  localparam int         SMLR_DISP_TENS    = 4;
  localparam int         SMLR_DISP_HUND    = 8;
  localparam int         SMLR_DISP_SYM     = 12;
  localparam int         SMLR_DISP_W       = 20;
  localparam logic [19:0] SMLR_DISP_RESET  = 20'h00000;

  // ==========================================================================
  // segment table, bit 7..0 = dp g f a b c d e
  localparam int         SMLR_NUM_DIGITS = 3;
  localparam logic [3:0] SMLR_MAX_DIGIT  = 4'h9;
  localparam logic [7:0] SMLR_SEG_BLANK  = 8'h00;
  localparam logic [7:0] SMLR_SEG_TABLE [0:9] = '{8'h3F, 8'h0C, 8'h5B, 8'h5E, 8'h64,
                                                   8'h76, 8'h77, 8'h1C, 8'h7F, 8'h7E};
  localparam logic [1:0] SMLR_SEL_SYM    = 2'h0;
  localparam logic [1:0] SMLR_SEL_HUND   = 2'h1;
  localparam logic [1:0] SMLR_SEL_TENS   = 2'h2;
  localparam logic [1:0] SMLR_SEL_UNITS  = 2'h3;
  localparam logic [1:0] SMLR_LAST_BYTE  = 2'h3;

  // ==========================================================================
  // serial timing: half period of the serial clock in system clocks per rate
  localparam logic [5:0] SMLR_HALF_DIV [0:3] = '{6'h04, 6'h08, 6'h10, 6'h20};
  localparam logic [5:0] SMLR_HALF_ONE  = 6'h01;
  localparam logic [3:0] SMLR_LAST_EDGE = 4'hF;
  localparam logic [3:0] SMLR_EDGE_ONE  = 4'h1;

  // ==========================================================================
  // refresh timing
  localparam int         SMLR_CLK_HZ          = 50_000_000;
  localparam int         SMLR_REFRESH_TIME_MS = 16;
  localparam int         SMLR_REFRESH_CYCLES  = SMLR_CLK_HZ / 1000 * SMLR_REFRESH_TIME_MS;
  localparam int         SMLR_REFRESH_W       = 20;

  typedef enum {SMLR_IDLE, SMLR_SHIFT} smlr_state_t;

endpackage

//--- logic/smlr_frame_if.sv
// frame byte request and answer between the sequencer and the segment encoder
`timescale 1ns/1ps
interface smlr_frame_if;
  logic [3:0] digit [0:2];
  logic [7:0] symbols;
  logic [1:0] byte_sel;
  logic       invert;
  logic [7:0] frame_byte;

  modport builder (input digit, input symbols, input byte_sel, input invert, output frame_byte);
  modport user    (output digit, output symbols, output byte_sel, output invert, input frame_byte);
endinterface

//--- logic/smlr_frame_build.sv
// segment encoder building the four display frame bytes
`timescale 1ns/1ps
module smlr_frame_build
  import smlr_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  smlr_frame_if.builder      fr
);

  logic [7:0] seg [0:2];
  logic [7:0] byte_next;
  logic [7:0] frame_byte_reg;

  // ==========================================================================
  // digit encoding, out-of-range digits go blank
  genvar gi;
  generate
    for (gi = 0; gi < SMLR_NUM_DIGITS; gi++) begin : g_digit
      assign seg[gi] = (fr.digit[gi] > SMLR_MAX_DIGIT) ? SMLR_SEG_BLANK : SMLR_SEG_TABLE[fr.digit[gi]];
    end
  endgenerate

  // ==========================================================================
  // byte order: symbols, hundreds, tens, units
  always_comb begin
    case (fr.byte_sel)
      SMLR_SEL_SYM:   byte_next = fr.symbols;
      SMLR_SEL_HUND:  byte_next = seg[0];
      SMLR_SEL_TENS:  byte_next = seg[1];
      SMLR_SEL_UNITS: byte_next = seg[2];
      default:        byte_next = SMLR_SEG_BLANK;
    endcase
  end

  // backplane bit stays zero in the plain frame; inverting flips all of it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frame_byte_reg <= SMLR_SEG_BLANK;
    end else begin
      frame_byte_reg <= fr.invert ? ~byte_next : byte_next;
    end
  end

  assign fr.frame_byte = frame_byte_reg;

endmodule // smlr_frame_build

//--- logic/smlr_top.sv
// serial master port with display refresh and APB register access
`timescale 1ns/1ps
module smlr_top
  import smlr_pkg::*;
#(
  parameter int REFRESH_CYCLES = SMLR_REFRESH_CYCLES
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_SERIAL_IN_LINE,
  output logic             O_SERIAL_OUT_LINE,
  output logic             O_SCK,
  output logic             O_IRQ
);

  // ==========================================================================
  // declarations
  logic [SMLR_CTRL_W-1:0]    ctrl_reg;
  logic [SMLR_EV_W-1:0]      ev_status_reg;
  logic [SMLR_EV_W-1:0]      ev_enable_reg;
  logic [SMLR_DISP_W-1:0]    disp_reg;
  logic [31:0]               prdata_reg;
  logic [7:0]                shift_reg;
  logic                      out_bit_reg;
  logic                      sck_reg;
  logic [3:0]                edge_cnt_reg;
  logic [5:0]                div_cnt_reg;
  smlr_state_t               state_reg;
  logic                      in_meta_reg;
  logic                      in_sync_reg;
  logic [SMLR_REFRESH_W-1:0] refresh_cnt_reg;
  logic                      frame_pending_reg;
  logic                      frame_active_reg;
  logic                      frame_wait_reg;
  logic [1:0]                byte_idx_reg;
  logic                      invert_reg;
  logic                      addr_ok;
  logic                      wr_en;
  logic                      rd_setup;
  logic                      sw_start;
  logic                      frame_start;
  logic                      xfer_start;
  logic [7:0]                start_byte;
  logic                      half_tick;
  logic                      sample_edge;
  logic                      xfer_done;
  logic                      frame_done;
  logic [SMLR_EV_W-1:0]      ev_set;
  logic [1:0]                rate;
  logic                      clock_polarity_select;
  logic                      clock_phase_select;
  logic                      busy;
  logic [31:0]               rd_mux;

  smlr_frame_if frame_bus ();

  assign rate = {ctrl_reg[SMLR_CTRL_RATE_HI], ctrl_reg[SMLR_CTRL_RATE_LO]};
  assign clock_polarity_select = ctrl_reg[SMLR_CTRL_CLOCK_POLARITY_SELECT];
  assign clock_phase_select = ctrl_reg[SMLR_CTRL_CLOCK_PHASE_SELECT];
  assign busy = (state_reg != SMLR_IDLE);

  // ==========================================================================
  // apb slave: zero wait states, read data captured in the setup cycle
  always_comb begin
    case (I_PADDR)
      SMLR_OFF_DATA, SMLR_OFF_CTRL, SMLR_OFF_STAT,
      SMLR_OFF_ICLR, SMLR_OFF_IEN, SMLR_OFF_DISP: addr_ok = 1'b1;
      default:                                    addr_ok = 1'b0;
    endcase
  end

  assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE & addr_ok;
  assign rd_setup  = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;

  // write-only and unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (I_PADDR)
      SMLR_OFF_DATA: rd_mux[7:0] = shift_reg;
      SMLR_OFF_CTRL: rd_mux[SMLR_CTRL_W-1:0] = ctrl_reg;
      SMLR_OFF_STAT: begin
        rd_mux[SMLR_EV_W-1:0] = ev_status_reg;
        rd_mux[SMLR_STAT_BUSY] = busy | frame_active_reg;
        rd_mux[SMLR_STAT_INV]  = invert_reg;
      end
      SMLR_OFF_IEN:  rd_mux[SMLR_EV_W-1:0] = ev_enable_reg;
      SMLR_OFF_DISP: rd_mux[SMLR_DISP_W-1:0] = disp_reg;
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  assign O_PRDATA = prdata_reg;

  // ==========================================================================
  // configuration registers
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      ctrl_reg <= SMLR_CTRL_RESET;
    end else if (wr_en && I_PADDR == SMLR_OFF_CTRL) begin
      ctrl_reg <= I_PWDATA[SMLR_CTRL_W-1:0];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      disp_reg <= SMLR_DISP_RESET;
    end else if (wr_en && I_PADDR == SMLR_OFF_DISP) begin
      disp_reg <= I_PWDATA[SMLR_DISP_W-1:0];
    end
  end

  // enables only gate the request; status records every event
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      ev_enable_reg <= SMLR_EV_RESET;
    end else if (wr_en && I_PADDR == SMLR_OFF_IEN) begin
      ev_enable_reg <= I_PWDATA[SMLR_EV_W-1:0];
    end
  end

  // ==========================================================================
  // interrupt status: a new event wins over a clear in the same cycle
  assign ev_set[SMLR_EV_XFER]  = xfer_done;
  assign ev_set[SMLR_EV_FRAME] = frame_done;

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      ev_status_reg <= SMLR_EV_RESET;
    end else if (wr_en && I_PADDR == SMLR_OFF_ICLR) begin
      ev_status_reg <= (ev_status_reg & ~I_PWDATA[SMLR_EV_W-1:0]) | ev_set;
    end else begin
      ev_status_reg <= ev_status_reg | ev_set;
    end
  end

  assign O_IRQ = |(ev_status_reg & ev_enable_reg);

  // ==========================================================================
  // serial input synchroniser
  // the data line changes with no relation to this clock
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      in_meta_reg <= 1'b0;
      in_sync_reg <= 1'b0;
    end else begin
      in_meta_reg <= I_SERIAL_IN_LINE;
      in_sync_reg <= in_meta_reg;
    end
  end

  // ==========================================================================
  // transfer start: software write ignored while any transfer or frame runs
  assign sw_start    = wr_en && (I_PADDR == SMLR_OFF_DATA) && !busy && !frame_active_reg;
  assign frame_start = frame_active_reg && !frame_wait_reg && !busy && !sw_start;
  assign xfer_start  = sw_start | frame_start;
  assign start_byte  = sw_start ? I_PWDATA[7:0] : frame_bus.frame_byte;

  // ==========================================================================
  // shift engine
  // at least four clocks per half period leave margin over the two-clock input synchroniser
  assign half_tick   = busy && (div_cnt_reg == SMLR_HALF_ONE);
  assign sample_edge = (edge_cnt_reg[0] == clock_phase_select);
  assign xfer_done   = half_tick && (edge_cnt_reg == SMLR_LAST_EDGE);

  // no abort: once started a byte always runs its sixteen edges
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state_reg <= SMLR_IDLE;
    end else begin
      case (state_reg)
        SMLR_IDLE:  if (xfer_start) state_reg <= SMLR_SHIFT;
        SMLR_SHIFT: if (xfer_done) state_reg <= SMLR_IDLE;
        default:    state_reg <= SMLR_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      div_cnt_reg  <= SMLR_HALF_ONE;
      edge_cnt_reg <= 4'h0;
    end else if (xfer_start) begin
      div_cnt_reg  <= SMLR_HALF_DIV[rate];
      edge_cnt_reg <= 4'h0;
    end else if (half_tick) begin
      div_cnt_reg  <= SMLR_HALF_DIV[rate];
      edge_cnt_reg <= edge_cnt_reg + SMLR_EDGE_ONE;
    end else if (busy) begin
      div_cnt_reg  <= div_cnt_reg - SMLR_HALF_ONE;
    end
  end

  // sixteen toggles per byte bring the clock back to its idle level
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      sck_reg <= 1'b0;
    end else if (!busy) begin
      sck_reg <= clock_polarity_select;
    end else if (half_tick) begin
      sck_reg <= ~sck_reg;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      shift_reg <= 8'h00;
    end else if (xfer_start) begin
      shift_reg <= start_byte;
    end else if (half_tick && sample_edge) begin
      shift_reg <= {shift_reg[6:0], in_sync_reg};
    end else if (!busy && wr_en && I_PADDR == SMLR_OFF_DATA) begin
      shift_reg <= shift_reg;
    end
  end

  // phase 0 presents the msb before the first edge; phase 1 on the leading edge
  // the last trailing edge moves nothing: the line keeps bit 0 until the next start
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      out_bit_reg <= 1'b0;
    end else if (xfer_start && !clock_phase_select) begin
      out_bit_reg <= start_byte[7];
    end else if (half_tick && !sample_edge && edge_cnt_reg != SMLR_LAST_EDGE) begin
      out_bit_reg <= shift_reg[7];
    end
  end

  assign O_SCK             = sck_reg;
  assign O_SERIAL_OUT_LINE = out_bit_reg;

  // ==========================================================================
  // refresh timer; 16 ms frames give a 31 Hz alternating drive
  // held at zero while disabled, so the first frame comes a full period later
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      refresh_cnt_reg <= '0;
    end else if (!ctrl_reg[SMLR_CTRL_REFRESH]) begin
      refresh_cnt_reg <= '0;
    end else if (refresh_cnt_reg == SMLR_REFRESH_W'(REFRESH_CYCLES - 1)) begin
      refresh_cnt_reg <= '0;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 1'b1;
    end
  end

  // a tick during a running frame is held, never dropped
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      frame_pending_reg <= 1'b0;
    end else if (!ctrl_reg[SMLR_CTRL_REFRESH]) begin
      frame_pending_reg <= 1'b0;
    end else if (refresh_cnt_reg == SMLR_REFRESH_W'(REFRESH_CYCLES - 1)) begin
      frame_pending_reg <= 1'b1;
    end else if (!frame_active_reg && !busy) begin
      frame_pending_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // frame sequencer: wait cycle lets the encoder register the next byte
  assign frame_done = frame_active_reg && xfer_done && (byte_idx_reg == SMLR_LAST_BYTE);

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      frame_active_reg <= 1'b0;
      frame_wait_reg   <= 1'b0;
      byte_idx_reg     <= SMLR_SEL_SYM;
    end else if (!frame_active_reg) begin
      frame_wait_reg <= 1'b1;
      byte_idx_reg   <= SMLR_SEL_SYM;
      if (frame_pending_reg && !busy) begin
        frame_active_reg <= 1'b1;
      end
    end else if (frame_done) begin
      frame_active_reg <= 1'b0;
    end else if (xfer_done) begin
      byte_idx_reg   <= byte_idx_reg + 2'h1;
      frame_wait_reg <= 1'b1;
    end else begin
      frame_wait_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      invert_reg <= 1'b0;
    end else if (frame_done) begin
      invert_reg <= ~invert_reg;
    end
  end

  // ==========================================================================
  // segment encoder; the display board latches the bytes it shifts
  assign frame_bus.digit[0] = disp_reg[SMLR_DISP_HUND +: SMLR_DIGIT_W];
  assign frame_bus.digit[1] = disp_reg[SMLR_DISP_TENS +: SMLR_DIGIT_W];
  assign frame_bus.digit[2] = disp_reg[SMLR_DISP_UNITS +: SMLR_DIGIT_W];
  assign frame_bus.symbols  = disp_reg[SMLR_DISP_SYM +: 8];
  assign frame_bus.byte_sel = byte_idx_reg;
  assign frame_bus.invert   = invert_reg;

  smlr_frame_build u_frame_build (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .fr      (frame_bus)
  );

endmodule // smlr_top

//--- testbench/smlr_top_assertions.sv
// checker for bus answers and serial clock timing of the serial master
`timescale 1ns/1ps
module smlr_top_assertions
  import smlr_pkg::*;
(
  input wire logic        I_MCLK,
  input wire logic        I_RESET,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        I_SERIAL_IN_LINE,
  input wire logic        O_SERIAL_OUT_LINE,
  input wire logic        O_SCK,
  input wire logic        O_IRQ
);
  logic [4:0] ctrl_sh;
  logic [5:0] gap_cnt;
  logic [2:0] pulse_cnt;
  logic       wr_ok;
  logic       bad_adr;
  assign wr_ok   = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  assign bad_adr = (I_PADDR > SMLR_OFF_DISP) || (I_PADDR[1:0] != 2'h0);
  // ==========================================================================
  // shadow state; 40 quiet cycles exceed any half period, so mean idle
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) ctrl_sh <= SMLR_CTRL_RESET;
    else if (wr_ok && I_PADDR == SMLR_OFF_CTRL) ctrl_sh <= I_PWDATA[4:0];
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) gap_cnt <= 6'h3F;
    else if ($changed(O_SCK)) gap_cnt <= 6'h00;
    else if (gap_cnt != 6'h3F) gap_cnt <= gap_cnt + 6'h01;
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) pulse_cnt <= 3'h0;
    else if (gap_cnt == 6'h28) pulse_cnt <= 3'h0;
    else if ($changed(O_SCK) && O_SCK != ctrl_sh[3]) pulse_cnt <= pulse_cnt + 3'h1;
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  chk_ready_high: assert property (O_PREADY) else $error("pready low");
  chk_err_map: assert property (I_PSEL && I_PENABLE |-> O_PSLVERR == bad_adr)
    else $error("pslverr does not match address");
  chk_half_per: assert property ($changed(O_SCK) && O_SCK == ctrl_sh[3] && ctrl_sh == $past(ctrl_sh, 3)
    && !ctrl_sh[4] |-> gap_cnt == SMLR_HALF_DIV[ctrl_sh[1:0]] - SMLR_HALF_ONE) else $error("sck half period");
  chk_pulse_cnt: assert property (gap_cnt == 6'h28 |-> pulse_cnt == 3'h0)
    else $error("sck pulses not a whole byte");
  chk_sample_hold: assert property ($changed(O_SCK) && O_SCK == (ctrl_sh[3] == ctrl_sh[2])
    |-> $stable(O_SERIAL_OUT_LINE)) else $error("data moved on sampling edge");
  chk_idle_lvl: assert property (gap_cnt == 6'h28 && $stable(ctrl_sh) |-> O_SCK == ctrl_sh[3])
    else $error("sck idle level");
  chk_start_xfer: assert property (wr_ok && I_PADDR == SMLR_OFF_DATA && gap_cnt >= 6'h28
    |-> ##[1:34] $changed(O_SCK)) else $error("data write did not start shifting");
  chk_clr_irq: assert property (wr_ok && I_PADDR == SMLR_OFF_ICLR && I_PWDATA[1:0] == 2'h3
    && gap_cnt >= 6'h28 |=> !O_IRQ) else $error("irq stays after clear");
  chk_mask_irq: assert property (wr_ok && I_PADDR == SMLR_OFF_IEN && I_PWDATA[1:0] == 2'h0
    |=> !O_IRQ) else $error("irq not masked");
endmodule // smlr_top_assertions

bind smlr_top smlr_top_assertions i_smlr_top_assertions (
  .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_SERIAL_IN_LINE(I_SERIAL_IN_LINE), .O_SERIAL_OUT_LINE(O_SERIAL_OUT_LINE),
  .O_SCK(O_SCK), .O_IRQ(O_IRQ));

//--- testbench/smlr_peer_model.sv
// behavioural serial-in parallel-out display board on the serial link
`timescale 1ns/1ps
module smlr_peer_model (
  input  wire logic       i_sck,
  input  wire logic       i_serial_out_line,
  input  wire logic       i_clock_polarity_select,
  input  wire logic       i_clock_phase_select,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_data,
  output logic            o_serial_in_line,
  output logic [7:0]      o_rx,
  output logic            o_byte_tgl
);
  logic [2:0] bit_cnt = 3'h0;
  initial o_byte_tgl = 1'b0;
  // ==========================================================================
  // capture on sampling edge, present next bit on the other edge
  // load after any polarity change: that idle toggle looks like an edge
  always @(i_sck or posedge i_load) begin
    if (i_load) begin
      o_rx             <= i_load_data;
      o_serial_in_line <= i_load_data[7];
      bit_cnt          <= 3'h0;
    end else if (i_sck === (i_clock_polarity_select == i_clock_phase_select)) begin
      o_rx    <= {o_rx[6:0], i_serial_out_line};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) o_byte_tgl <= !o_byte_tgl;
    end else begin
      o_serial_in_line <= o_rx[7];
    end
  end
endmodule // smlr_peer_model

//--- testbench/smlr_top_test.sv
// self-checking bench for the serial master with display refresh
`timescale 1ns/1ps
module smlr_top_test;
  import smlr_pkg::*;
  localparam int REFRESH = 2000;
  logic        clk, rst, psel, pen, pwr, sin, sout, sck, irq, pready, pslverr;
  logic        clock_polarity_select, clock_phase_select, pld, ptgl;
  logic [7:0]  paddr, pdat, prx;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rxq[$];
  logic [7:0]  seg[0:9] = '{8'h3F, 8'h0C, 8'h5B, 8'h5E, 8'h64, 8'h76, 8'h77, 8'h1C, 8'h7F, 8'h7E};
  int          err_count, n_tests;

  smlr_top #(.REFRESH_CYCLES(REFRESH)) i_smlr_top (.I_MCLK(clk), .I_RESET(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SERIAL_IN_LINE(sin), .O_SERIAL_OUT_LINE(sout),
    .O_SCK(sck), .O_IRQ(irq));
  smlr_peer_model i_smlr_peer_model (.i_sck(sck), .i_serial_out_line(sout), .i_clock_polarity_select(clock_polarity_select),
    .i_clock_phase_select(clock_phase_select), .i_load(pld), .i_load_data(pdat), .o_serial_in_line(sin), .o_rx(prx),
    .o_byte_tgl(ptgl));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(ptgl) rxq.push_back(prx);
  // ==========================================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    check("pready", 32'h1, {31'h0, pready});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic load_peer(input logic c_pol, input logic c_pha, input logic [7:0] v);
    clock_polarity_select <= c_pol;
    clock_phase_select <= c_pha;
    repeat (3) @(posedge clk);
    pdat <= v;
    pld  <= 1'b1;
    @(posedge clk);
    pld <= 1'b0;
  endtask
  function automatic logic [7:0] segx(input logic [3:0] d);
    return (d > 4'h9) ? 8'h00 : seg[d];
  endfunction
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    rd(SMLR_OFF_CTRL, q);
    check("ctrl reset", 32'h0, q);
    rd(SMLR_OFF_STAT, q);
    check("stat reset", 32'h0, q);
    rd(SMLR_OFF_DISP, q);
    check("disp reset", 32'h0, q);
    check("sck idle", 32'h0, {31'h0, sck});
    $display("test reset done");
  endtask
  task automatic t_xfer(input logic cp, input logic ch, input logic [1:0] rt, input logic [7:0] tx,
                        input logic [7:0] ptx);
    logic [31:0] q;
    time         t0;
    int          n, cyc, h;
    h = SMLR_HALF_DIV[rt];
    wr(SMLR_OFF_CTRL, {28'h0, cp, ch, rt});
    load_peer(cp, ch, ptx);
    check("sck idle level", {31'h0, cp}, {31'h0, sck});
    wr(SMLR_OFF_ICLR, 32'h3);
    wr(SMLR_OFF_DATA, {24'h0, tx});
    t0 = $time;
    wr(SMLR_OFF_DATA, {24'h0, ~tx});
    n = 0;
    do begin
      rd(SMLR_OFF_STAT, q);
      n++;
    end while (q[SMLR_EV_XFER] !== 1'b1 && n < 400);
    cyc = int'(($time - t0) / 20);
    check("done flag", 32'h1, {31'h0, q[SMLR_EV_XFER]});
    check("xfer length", 32'h1, {31'h0, cyc >= 16 * h && cyc <= 16 * h + 8});
    check("board byte", {24'h0, tx}, {24'h0, prx});
    rd(SMLR_OFF_DATA, q);
    check("received byte", {24'h0, ptx}, q);
    $display("test transfer mode %0d%0d rate %0d done", cp, ch, rt);
  endtask
  task automatic t_irq;
    logic [31:0] q;
    logic        e;
    wr(SMLR_OFF_IEN, 32'h1);
    @(negedge clk);
    check("irq raised", 32'h1, {31'h0, irq});
    wr(SMLR_OFF_IEN, 32'h0);
    @(negedge clk);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(SMLR_OFF_IEN, 32'h1);
    wr(SMLR_OFF_ICLR, 32'h3);
    @(negedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h40, 32'h0, q, e);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    $display("test interrupt done");
  endtask
  task automatic t_frame;
    logic [19:0] disp[0:3] = '{20'h00375, 20'h5A012, 20'h00468, 20'h009FA};
    logic [7:0]  ex[0:3];
    logic [7:0]  inv;
    time         tp, tf;
    logic [31:0] q;
    int          n, sp;
    wr(SMLR_OFF_CTRL, 32'h0);
    load_peer(1'b0, 1'b0, 8'h00);
    rxq.delete();
    for (int k = 0; k < 4; k++) begin
      wr(SMLR_OFF_DISP, {12'h0, disp[k]});
      if (k == 0) wr(SMLR_OFF_CTRL, 32'h10);
      n = 0;
      while (rxq.size() < 4 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      tf = $time;
      inv = k[0] ? 8'hFF : 8'h00;
      ex = '{disp[k][19:12], segx(disp[k][11:8]), segx(disp[k][7:4]), segx(disp[k][3:0])};
      for (int j = 0; j < 4; j++) begin
        check("frame byte", {24'h0, ex[j] ^ inv}, {24'h0, rxq.pop_front()});
      end
      sp = int'((tf - tp) / 20);
      if (k > 0) check("frame spacing", 32'h1, {31'h0, sp >= REFRESH - 4 && sp <= REFRESH + 4});
      tp = tf;
    end
    repeat (8) @(posedge clk);
    rd(SMLR_OFF_STAT, q);
    check("frame status", 32'h3, q & 32'h00000303);
    $display("test frame done");
  endtask
  // ==========================================================================
  // run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #800_000;
    err_count++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, clock_polarity_select, clock_phase_select, pld} = 6'h00;
    {paddr, pdat, pwdata} = 48'h0;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_xfer(1'b0, 1'b0, 2'h0, 8'hA5, 8'h3C);
    t_xfer(1'b0, 1'b1, 2'h1, 8'h81, 8'hC3);
    t_xfer(1'b1, 1'b0, 2'h2, 8'h7E, 8'h01);
    t_xfer(1'b1, 1'b1, 2'h3, 8'h5A, 8'hF0);
    t_irq();
    t_frame();
    final_report();
  end
endmodule // smlr_top_test
